// >>> verilog/dofs_top.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module dofs_top
	import dofs_pkg::*;
#(
	parameter int INDEX_HOLD_CYC = DOFS_INDEX_HOLD_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [DOFS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic st_running,
	input wire logic st_forward,
	input wire logic st_reverse,
	input wire logic st_jogging,
	input wire logic st_fault,
	input wire logic freq_level_detect_one,
	input wire logic freq_level_detect_two,
	input wire logic st_freq_reached,
	input wire logic st_out_freq_zero,
	input wire logic st_ref_freq_zero,
	input wire logic st_upper_limit,
	input wire logic st_lower_limit,
	input wire logic st_powered,
	input wire logic st_protect_active,
	input wire logic st_ready,
	input wire logic st_preexcite,
	input wire logic st_overload_alarm,
	input wire logic st_underload_alarm,
	input wire logic st_seq_stage_done,
	input wire logic st_seq_cycle_done,
	input wire logic st_dcbus_ok,
	input wire logic encoder_index_pin,
	input wire logic st_pulse_super,
	input wire logic safe_torque_off,
	input wire logic pulse_train_in,
	output logic relay_one_out,
	output logic relay_two_out,
	output logic oc_out,
	output logic fast_pulse_output
);

	// ****************
	// registers
	// ****************
	logic [DOFS_SEL_W-1:0] sel_reg [DOFS_NTERM];
	logic fast_type_reg;
	logic [DOFS_NVSRC*DOFS_VBIT_STRIDE-1:0] vbit_reg;
	logic [DOFS_NTERM-1:0] istat_reg;
	logic [DOFS_NTERM-1:0] imask_reg;
	logic [DOFS_NTERM-1:0] term_reg;
	logic [DOFS_NTERM-1:0] term_next;
	logic fast_reg;

	logic wr_sel;
	logic wr_ctrl;
	logic wr_vbit;
	logic wr_istat;
	logic wr_imask;

	assign wr_sel = ce && reg_wr && (reg_addr == DOFS_SEL_REG_ADDR);
	assign wr_ctrl = ce && reg_wr && (reg_addr == DOFS_CTRL_REG_ADDR);
	assign wr_vbit = ce && reg_wr && (reg_addr == DOFS_VBIT_REG_ADDR);
	assign wr_istat = ce && reg_wr && (reg_addr == DOFS_ISTAT_REG_ADDR);
	assign wr_imask = ce && reg_wr && (reg_addr == DOFS_IMASK_REG_ADDR);

	// ****************
	// encoder index pin
	// ****************
	logic [2:0] idx_sync_reg;
	logic idx_level_reg;
	logic [DOFS_HOLD_W-1:0] hold_reg;
	logic idx_rise;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idx_sync_reg <= 3'h0;
		end else if (ce) begin
			idx_sync_reg <= {idx_sync_reg[1:0], encoder_index_pin};
		end
	end

	// level only moves once the two back stages agree
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idx_level_reg <= 1'b0;
		end else if (ce && (idx_sync_reg[1] == idx_sync_reg[2])) begin
			idx_level_reg <= idx_sync_reg[2];
		end
	end

	assign idx_rise = (idx_sync_reg[1] == idx_sync_reg[2]) && idx_sync_reg[2] && !idx_level_reg;

	// index hold timer
	// a new index pulse restarts the full hold time
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hold_reg <= '0;
		end else if (ce) begin
			if (idx_rise) begin
				hold_reg <= DOFS_HOLD_W'(INDEX_HOLD_CYC);
			end else if (hold_reg != '0) begin
				hold_reg <= hold_reg - DOFS_HOLD_W'(1);
			end
		end
	end

	// ****************
	// condition table
	// ****************
	logic [63:0] cond;

	always_comb begin
		cond = 64'h0;
		cond[DOFS_F_RUN] = st_running;
		cond[DOFS_F_FWD] = st_running && st_forward;
		cond[DOFS_F_REV] = st_running && st_reverse;
		cond[DOFS_F_JOG] = st_running && st_jogging;
		cond[DOFS_F_FAULT] = st_fault;
		cond[DOFS_F_LVL_ONE] = freq_level_detect_one;
		cond[DOFS_F_LVL_TWO] = freq_level_detect_two;
		cond[DOFS_F_REACH] = st_freq_reached;
		cond[DOFS_F_ZERO] = st_out_freq_zero && st_ref_freq_zero;
		cond[DOFS_F_UPPER] = st_upper_limit;
		cond[DOFS_F_LOWER] = st_lower_limit;
		cond[DOFS_F_READY] = st_powered && !st_protect_active && st_ready;
		cond[DOFS_F_PREEX] = st_preexcite;
		cond[DOFS_F_OVL] = st_overload_alarm;
		cond[DOFS_F_UNL] = st_underload_alarm;
		cond[DOFS_F_STAGE] = st_seq_stage_done;
		cond[DOFS_F_CYCLE] = st_seq_cycle_done;
		cond[DOFS_F_DCBUS] = st_dcbus_ok;
		cond[DOFS_F_INDEX] = (hold_reg != '0);
		cond[DOFS_F_SUPER] = st_pulse_super;
		cond[DOFS_F_SAFE_OFF] = safe_torque_off;
	end

	// ****************
	// per terminal
	// ****************
	genvar gi;
	generate
		for (gi = 0; gi < DOFS_NTERM; gi++) begin : g_term
			logic [63:0] tcond;

			// virtual bits are per terminal, per source
			always_comb begin
				tcond = cond;
				for (int s = 0; s < DOFS_NVSRC; s++) begin
					tcond[DOFS_F_VBIT0 + s] = vbit_reg[s*DOFS_VBIT_STRIDE + gi];
				end
			end

			assign term_next[gi] = tcond[sel_reg[gi]];
		end
	endgenerate

	// one process owns the whole selector array, so it has a single driver
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int t = 0; t < DOFS_NTERM; t++) begin
				sel_reg[t] <= DOFS_SEL_RST;
			end
		end else if (wr_sel) begin
			for (int t = 0; t < DOFS_NTERM; t++) begin
				sel_reg[t] <= reg_wdata[t*DOFS_SEL_STRIDE +: DOFS_SEL_W];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			term_reg <= '0;
		end else if (ce) begin
			term_reg <= term_next;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fast_reg <= 1'b0;
		end else if (ce) begin
			if (fast_type_reg == DOFS_FAST_SWITCH) begin
				fast_reg <= term_next[DOFS_T_FAST];
			end else begin
				fast_reg <= pulse_train_in;
			end
		end
	end

	assign relay_one_out = term_reg[DOFS_T_RLY1];
	assign relay_two_out = term_reg[DOFS_T_RLY2];
	assign oc_out = term_reg[DOFS_T_OC];
	assign fast_pulse_output = fast_reg;

	// ****************
	// control registers
	// ****************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fast_type_reg <= DOFS_FAST_TYPE_RST;
		end else if (wr_ctrl) begin
			fast_type_reg <= reg_wdata[DOFS_CTRL_FAST_TYPE_BIT];
		end
	end

	// remote master writes 1 for on, 0 for off
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			vbit_reg <= '0;
		end else if (wr_vbit) begin
			vbit_reg <= reg_wdata[DOFS_NVSRC*DOFS_VBIT_STRIDE-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			imask_reg <= '0;
		end else if (wr_imask) begin
			imask_reg <= reg_wdata[DOFS_NTERM-1:0];
		end
	end

	// ****************
	// interrupts
	// ****************
	logic [DOFS_NTERM-1:0] ev_on;
	logic [DOFS_NTERM-1:0] clr_bits;

	// event: a terminal switching on; a fresh event beats a same-cycle clear
	assign ev_on = ce ? (term_next & ~term_reg) : '0;
	assign clr_bits = wr_istat ? reg_wdata[DOFS_NTERM-1:0] : '0;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			istat_reg <= '0;
		end else begin
			istat_reg <= (istat_reg & ~clr_bits) | ev_on;
		end
	end

	assign irq = |(istat_reg & imask_reg);

	// ****************
	// read port
	// ****************
	logic [31:0] rd_next;

	always_comb begin
		rd_next = 32'h0;
		case (reg_addr)
			DOFS_SEL_REG_ADDR: begin
				for (int t = 0; t < DOFS_NTERM; t++) begin
					rd_next[t*DOFS_SEL_STRIDE +: DOFS_SEL_W] = sel_reg[t];
				end
			end
			DOFS_CTRL_REG_ADDR: rd_next[DOFS_CTRL_FAST_TYPE_BIT] = fast_type_reg;
			DOFS_VBIT_REG_ADDR: rd_next[DOFS_NVSRC*DOFS_VBIT_STRIDE-1:0] = vbit_reg;
			DOFS_OUT_REG_ADDR: rd_next[DOFS_NTERM-1:0] = term_reg;
			DOFS_ISTAT_REG_ADDR: rd_next[DOFS_NTERM-1:0] = istat_reg;
			DOFS_IMASK_REG_ADDR: rd_next[DOFS_NTERM-1:0] = imask_reg;
			default: rd_next = 32'h0;
		endcase
	end

	// data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (ce) begin
			reg_rdata <= reg_rd ? rd_next : 32'h0;
		end
	end

endmodule : dofs_top

// >>> verilog/dofs_pkg.sv
// Operation
// - each of four terminals has its own selector; shared values act independently
// - fast terminal is either a pulse output or a selected on/off output
// - fast output type 0 gives pulse mode, 1 gives switched digital output
// - selector value 0 does nothing and keeps terminal off
// - values 1-4 follow running, forward, reverse, jogging with output frequency
// - value 5 is on while the drive is faulted
// - values 6, 7 follow level detectors one and two; 8 follows frequency reached
// - value 9 is on only when output and reference frequency are zero
// - values 10, 11 are on at upper and lower limit frequency
// - value 12 is on when powered, unprotected and ready to run
// - value 13 is on during motor pre-excitation
// - values 14, 15 follow overload and underload pre-alarms
// - value 16 marks sequencer stage done, 17 a full sequencer cycle
// - values 23-25 follow virtual bits written by a remote master
// - value 26 is on while bus voltage exceeds undervoltage threshold
// - value 27 turns on at encoder index and off 10 ms later
// - value 28 is on while pulse superposition is active
// - value 29 is on after a safe torque off fault
package dofs_pkg;
	localparam int DOFS_NTERM = 4;
	localparam int DOFS_SEL_W = 6;
	localparam int DOFS_ADDR_W = 8;

	// terminal index: relay one, relay two, open collector, fast output
	localparam int DOFS_T_RLY1 = 0;
	localparam int DOFS_T_RLY2 = 1;
	localparam int DOFS_T_OC = 2;
	localparam int DOFS_T_FAST = 3;

	// ****************
	// register map
	// ****************
	localparam logic [7:0] DOFS_SEL_REG_ADDR = 8'h00;
	localparam logic [7:0] DOFS_CTRL_REG_ADDR = 8'h04;
	localparam logic [7:0] DOFS_VBIT_REG_ADDR = 8'h08;
	localparam logic [7:0] DOFS_OUT_REG_ADDR = 8'h0C;
	localparam logic [7:0] DOFS_ISTAT_REG_ADDR = 8'h10;
	localparam logic [7:0] DOFS_IMASK_REG_ADDR = 8'h14;

	// selector n occupies bits [8n+5:8n]
	localparam int DOFS_SEL_STRIDE = 8;
	localparam int DOFS_CTRL_FAST_TYPE_BIT = 0;
	// virtual bit of source s for terminal n sits at bit 4s+n
	localparam int DOFS_VBIT_STRIDE = 4;
	localparam logic [DOFS_SEL_W-1:0] DOFS_SEL_RST = 6'h00;
	localparam logic DOFS_FAST_TYPE_RST = 1'b0;
	localparam logic DOFS_FAST_PULSE = 1'b0;
	localparam logic DOFS_FAST_SWITCH = 1'b1;

	// selector values
	localparam int DOFS_F_RUN = 1;
	localparam int DOFS_F_FWD = 2;
	localparam int DOFS_F_REV = 3;
	localparam int DOFS_F_JOG = 4;
	localparam int DOFS_F_FAULT = 5;
	localparam int DOFS_F_LVL_ONE = 6;
	localparam int DOFS_F_LVL_TWO = 7;
	localparam int DOFS_F_REACH = 8;
	localparam int DOFS_F_ZERO = 9;
	localparam int DOFS_F_UPPER = 10;
	localparam int DOFS_F_LOWER = 11;
	localparam int DOFS_F_READY = 12;
	localparam int DOFS_F_PREEX = 13;
	localparam int DOFS_F_OVL = 14;
	localparam int DOFS_F_UNL = 15;
	localparam int DOFS_F_STAGE = 16;
	localparam int DOFS_F_CYCLE = 17;
	localparam int DOFS_F_VBIT0 = 23;
	localparam int DOFS_F_DCBUS = 26;
	localparam int DOFS_F_INDEX = 27;
	localparam int DOFS_F_SUPER = 28;
	localparam int DOFS_F_SAFE_OFF = 29;
	localparam int DOFS_NVSRC = 3;

	// ****************
	// timing
	// ****************
	localparam int DOFS_CLK_KHZ = 200000;
	localparam int DOFS_INDEX_HOLD_MS = 10;
	localparam int DOFS_INDEX_HOLD_CYC = DOFS_INDEX_HOLD_MS * DOFS_CLK_KHZ;
	localparam int DOFS_HOLD_W = 22;
endpackage : dofs_pkg

// >>> verification/dofs_top_properties.sv
`timescale 1ns/10ps
module dofs_top_properties
	import dofs_pkg::*;
(
	input logic ref_clk,
	input logic rstn,
	input logic ce,
	input logic [DOFS_ADDR_W-1:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic st_fault,
	input logic encoder_index_pin,
	input logic pulse_train_in,
	input logic relay_one_out,
	input logic relay_two_out,
	input logic oc_out,
	input logic fast_pulse_output
);
	logic [31:0] sel_reg;
	logic ctl_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// shadow copies, since selectors are not visible at the ports
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sel_reg <= 32'h0;
			ctl_reg <= 1'b0;
		end else if (ce && reg_wr) begin
			if (reg_addr == DOFS_SEL_REG_ADDR) sel_reg <= reg_wdata;
			if (reg_addr == DOFS_CTRL_REG_ADDR) ctl_reg <= reg_wdata[0];
		end
	end
	sequence s_idx_rise;
		ce && sel_reg[5:0] == 6'h1B && $rose(encoder_index_pin);
	endsequence
	property p_idx; s_idx_rise |-> ##[1:8] relay_one_out; endproperty
	a_idx: assert property (p_idx) else $error("index");
	property p_off; ce && sel_reg[5:0] == 6'h00 |=> !relay_one_out; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_flt; ce && sel_reg[5:0] == 6'h05 |=> relay_one_out == $past(st_fault); endproperty
	a_flt: assert property (p_flt) else $error("fault");
	property p_oc; ce && sel_reg[21:16] == 6'h05 |=> oc_out == $past(st_fault); endproperty
	a_oc: assert property (p_oc) else $error("oc");
	property p_rsv; ce && sel_reg[13:8] inside {[6'h12:6'h16]} |=> !relay_two_out; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_sw;
		ce && ctl_reg && sel_reg[29:24] == 6'h05 |=> fast_pulse_output == $past(st_fault);
	endproperty
	a_sw: assert property (p_sw) else $error("switched");
	property p_pls; ce && !ctl_reg |=> fast_pulse_output == $past(pulse_train_in); endproperty
	a_pls: assert property (p_pls) else $error("pulse");
	property p_rd; !(ce && reg_rd) |=> reg_rdata == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("rdata");
endmodule : dofs_top_properties

// >>> verification/dofs_field.sv
`timescale 1ns/10ps
module dofs_field (
	input logic ref_clk,
	input logic idx_go,
	output logic idx_pin,
	output logic ptrain
);
	logic [1:0] cnt = 2'h0;
	logic [2:0] div = 3'h0;
	initial idx_pin = 1'b0;
	initial ptrain = 1'b0;
	always @(posedge ref_clk) begin
		div <= div + 3'h1;
		ptrain <= div[2];
		idx_pin <= idx_go || cnt != 2'h0;
		cnt <= idx_go ? 2'h3 : (cnt == 2'h0 ? 2'h0 : cnt - 2'h1);
	end
endmodule : dofs_field

// >>> verification/tb_dofs_top.sv
`timescale 1ns/10ps
module tb_dofs_top;
	import dofs_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_q = 1'b0;
	logic idx_go = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [22:0] stv = 23'h0;
	logic [31:0] reg_rdata, vb, ew;
	logic [31:0] rnd = 32'h6AAD;
	logic irq, r1, r2, oc, fp, idx_pin, ptrain;
	logic [31:0] q[$];
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	dofs_top #(.INDEX_HOLD_CYC(20)) dofs_top_inst (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .st_running(stv[0]), .st_forward(stv[1]),
		.st_reverse(stv[2]), .st_jogging(stv[3]), .st_fault(stv[4]),
		.freq_level_detect_one(stv[5]), .freq_level_detect_two(stv[6]),
		.st_freq_reached(stv[7]), .st_out_freq_zero(stv[8]), .st_ref_freq_zero(stv[9]),
		.st_upper_limit(stv[10]), .st_lower_limit(stv[11]), .st_powered(stv[12]),
		.st_protect_active(stv[13]), .st_ready(stv[14]), .st_preexcite(stv[15]),
		.st_overload_alarm(stv[16]), .st_underload_alarm(stv[17]),
		.st_seq_stage_done(stv[18]), .st_seq_cycle_done(stv[19]), .st_dcbus_ok(stv[20]),
		.encoder_index_pin(idx_pin), .st_pulse_super(stv[21]), .safe_torque_off(stv[22]),
		.pulse_train_in(ptrain), .relay_one_out(r1), .relay_two_out(r2), .oc_out(oc),
		.fast_pulse_output(fp));
	dofs_field dofs_field_inst (.ref_clk(ref_clk), .idx_go(idx_go), .idx_pin(idx_pin),
		.ptrain(ptrain));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// expected terminal state for selector v, status bits s, terminal t
	function automatic logic fn(input int v, input logic [22:0] s, input int t);
		case (v)
			1: return s[0];
			2, 3, 4: return s[0] & s[v-1];
			5, 6, 7, 8, 10, 11: return s[v-1+(v>9)];
			9: return s[8] & s[9];
			12: return s[12] & !s[13] & s[14];
			13, 14, 15, 16, 17: return s[v+2];
			23, 24, 25: return vb[4*(v-23)+t];
			26, 28, 29: return s[v-7+(v==26)];
			default: return 1'b0;
		endcase
	endfunction : fn
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic give_verdict();
		if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	// one idle edge after each strobe, so no strobe is set twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : rd
	always @(posedge ref_clk) begin
		if (rd_q) chk(reg_rdata, q.pop_front());
		rd_q <= reg_rd;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		int v;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
		wr(8'h04, 32'h1);
		for (int p = 0; p < 64; p++) begin
			v = p % 32;
			rnd = xs(rnd);
			stv <= rnd[22:0];
			rnd = xs(rnd);
			vb = {20'h0, rnd[11:0]};
			wr(8'h08, vb);
			wr(8'h00, {4{2'b00, v[5:0]}});
			repeat (2) @(posedge ref_clk);
			ew = 32'h0;
			for (int t = 0; t < 4; t++) ew[t] = fn(v, stv, t);
			chk({28'h0, fp, oc, r2, r1}, ew);
			rd(8'h0C, ew);
		end
		stv <= 23'h0;
		wr(8'h00, 32'h05050505);
		wr(8'h04, 32'h0);
		wr(8'h10, 32'hF);
		stv <= 23'h10;
		repeat (3) @(posedge ref_clk);
		rd(8'h10, 32'hF);
		rd(8'h0C, 32'hF);
		chk({31'h0, irq}, 32'h0);
		wr(8'h14, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(8'h10, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(8'h10, 32'hE);
		wr(8'h0C, 32'h0);
		rd(8'h0C, 32'hF);
		wr(8'h00, 32'h1B);
		idx_go <= 1'b1;
		@(posedge ref_clk);
		idx_go <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd(8'h0C, 32'h1);
		repeat (30) @(posedge ref_clk);
		rd(8'h0C, 32'h0);
		// clock enable low: the selector write and the fault must both be ignored
		ce <= 1'b0;
		wr(8'h00, 32'h05050505);
		stv <= 23'h10;
		repeat (2) @(posedge ref_clk);
		chk({29'h0, oc, r2, r1}, 32'h0);
		ce <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({29'h0, oc, r2, r1}, 32'h0);
		rd(8'h00, 32'h1B);
		give_verdict();
	end
endmodule : tb_dofs_top
bind dofs_top dofs_top_properties dofs_top_properties_inst (.*);
